//--- rtl/flp_pkg.sv
package flp_pkg;
  // local clock
  localparam int CLK_HZ = 25000000;
  localparam int NS_PER_CLK = 40;
  localparam int CYC_PER_US = 1000 / NS_PER_CLK; // cycles in one microsecond
  // chosen timer values, each inside its allowed range
  localparam int FLP_MIN_US = 10;
  localparam int FLP_MAX_US = 175;
  localparam int DATA_MIN_US = 30;
  localparam int DATA_MAX_US = 90;
  localparam int NLP_MIN_US = 6000;
  localparam int NLP_MAX_US = 100000;
  // least times round up, longest times round down
  localparam int FLP_MIN_CYC = (FLP_MIN_US * 1000 + NS_PER_CLK - 1) / NS_PER_CLK;
  localparam int FLP_MAX_CYC = (FLP_MAX_US * 1000) / NS_PER_CLK;
  localparam int DATA_MIN_CYC = (DATA_MIN_US * 1000 + NS_PER_CLK - 1) / NS_PER_CLK;
  localparam int DATA_MAX_CYC = (DATA_MAX_US * 1000) / NS_PER_CLK;
  localparam int NLP_MIN_CYC = (NLP_MIN_US * 1000 + NS_PER_CLK - 1) / NS_PER_CLK;
  localparam int NLP_MAX_CYC = (NLP_MAX_US * 1000) / NS_PER_CLK;
  // pulse count for ability detection, 6..17
  localparam int ABLE_PULSES = 8;
  // bursts needed for acknowledge detect
  localparam int MATCH_BURSTS = 3;
  // word layout
  localparam int WORD_BITS = 16;
  localparam int ACK_BIT = 14;
  localparam int RSV_LO = 10;
  localparam int RSV_HI = 12;
  localparam logic [15:0] ACK_MASK = 16'hbfff;
endpackage

//--- rtl/flp_span_timer.sv
`timescale 1ns/1ns
// free counter of cycles since last restart, saturating
module flp_span_timer #(
  parameter int WIDTH = 22
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic restart,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] nxt_count;
  logic [WIDTH-1:0] count_ff;

  initial
  begin
    if (WIDTH < 8)
    begin
      $error("flp_span_timer width too small");
    end
  end

  // saturate so a long idle never wraps into a legal window
  always_comb
  begin
    nxt_count = count_ff;
    if (restart)
    begin
      nxt_count = '0;
    end
    else if (count_ff != '1)
    begin
      nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      count_ff <= '0;
    end
    else
    begin
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;
endmodule

//--- rtl/flp_burst_receive_checker.sv
`timescale 1ns/1ns
// Behaviour
// - transmitter sends three reserved bits zero
// - reserved bits set to one still accepted
// - burst valid only inside burst spacing window; here outside it only restarts the match chain, word still reported
// - burst minimum spacing 5 to 7 ms
// - burst maximum spacing 50 to 150 ms
// - ability after six to seventeen good pulses
// - pulse spacing window gates ability detection
// - pulse minimum spacing 5 to 25 us
// - pulse maximum spacing 165 to 185 us
// - data one only inside data window
// - data window opens 15 to 47 us
// - data window closes 78 to 100 us
// - late data pulse becomes zero, new clock
// - ability burst counts toward acknowledge detect
// - three consistent bursts, ignoring acknowledge bit
// - keep first sixteen bits, drop extras
module flp_burst_receive_checker #(
  parameter int CYC_PER_US = flp_pkg::CYC_PER_US
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic LINK_PULSE,
  output logic ABILITY_DETECTED,
  output logic ACK_DETECT,
  output logic WORD_VALID,
  output logic [15:0] RX_WORD
);
  localparam int TW = 22;
  // terminal counts follow the cycle scale; the default scale gives the package counts
  localparam int FLP_MIN_C = flp_pkg::FLP_MIN_US * CYC_PER_US;
  localparam int FLP_MAX_C = flp_pkg::FLP_MAX_US * CYC_PER_US;
  localparam int DATA_MIN_C = flp_pkg::DATA_MIN_US * CYC_PER_US;
  localparam int DATA_MAX_C = flp_pkg::DATA_MAX_US * CYC_PER_US;
  localparam int NLP_MIN_C = flp_pkg::NLP_MIN_US * CYC_PER_US;
  localparam int NLP_MAX_C = flp_pkg::NLP_MAX_US * CYC_PER_US;

  // a saturating timer narrower than the longest window would never see it expire
  if (CYC_PER_US < 1 || NLP_MAX_C >= 2 ** TW - 1)
  begin
    $error("burst timer too narrow for this clock scale");
  end

  typedef enum logic [1:0] {IDLE, WAIT_DATA, WAIT_CLOCK} rx_state_t;

  // two-flop synchroniser, then edge detect on the second stage only
  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic pulse;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= LINK_PULSE;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  assign pulse = sync2_ff & ~prev_ff;

  // timers since last clock pulse, since burst start and since any pulse
  logic [TW-1:0] clk_gap;
  logic [TW-1:0] pulse_gap;
  logic [TW-1:0] burst_gap;
  logic [TW-1:0] end_gap;
  logic clk_restart;
  logic burst_restart;

  flp_span_timer #(.WIDTH(TW)) u_clk_timer (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .restart(clk_restart),
    .count(clk_gap)
  );

  flp_span_timer #(.WIDTH(TW)) u_burst_timer (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .restart(burst_restart),
    .count(burst_gap)
  );

  flp_span_timer #(.WIDTH(TW)) u_pulse_timer (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .restart(pulse),
    .count(pulse_gap)
  );

  // cycle comparisons against chosen terminal counts
  function automatic logic at_least(input logic [TW-1:0] v, input int lim);
    return v >= TW'(lim);
  endfunction

  rx_state_t state_ff, nxt_state;
  logic [15:0] shift_ff, nxt_shift;
  logic [5:0] bits_ff, nxt_bits;
  logic [4:0] good_ff, nxt_good;
  logic able_ff, nxt_able;
  logic [1:0] match_ff, nxt_match;
  logic [15:0] last_ff, nxt_last;
  logic have_last_ff, nxt_have_last;
  logic ack_ff, nxt_ack;
  logic valid_ff, nxt_valid;
  logic [15:0] word_ff, nxt_word;
  logic [TW-1:0] since_end_ff, nxt_since_end;
  logic spaced_ok;
  logic burst_over;
  logic data_one;
  logic late;

  assign end_gap = since_end_ff;
  // burst ends when no clock arrives within the pulse maximum
  assign burst_over = (state_ff != IDLE) && at_least(clk_gap, FLP_MAX_C);
  // start-to-start above minimum, end-to-start below maximum
  assign spaced_ok = at_least(burst_gap, NLP_MIN_C)
    && !at_least(end_gap, NLP_MAX_C);
  assign data_one = at_least(clk_gap, DATA_MIN_C)
    && !at_least(clk_gap, DATA_MAX_C);
  assign late = at_least(clk_gap, DATA_MAX_C);
  assign clk_restart = pulse && (state_ff != WAIT_DATA || late || !data_one);
  assign burst_restart = pulse && state_ff == IDLE;

  // receive sequencing and word building
  always_comb
  begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bits = bits_ff;
    nxt_good = good_ff;
    nxt_able = able_ff;
    nxt_match = match_ff;
    nxt_last = last_ff;
    nxt_have_last = have_last_ff;
    nxt_ack = ack_ff;
    nxt_valid = 1'b0;
    nxt_word = word_ff;
    nxt_since_end = (since_end_ff == '1) ? since_end_ff : since_end_ff + TW'(1);
    unique case (state_ff)
      IDLE:
      begin
        if (pulse)
        begin
          nxt_state = WAIT_DATA;
          nxt_shift = '0;
          nxt_bits = '0;
          nxt_good = 5'd1;
          // spacing check from previous burst; first burst seeds the chain
          if (have_last_ff && !spaced_ok)
          begin
            nxt_match = '0;
            nxt_have_last = 1'b0;
          end
        end
      end
      WAIT_DATA, WAIT_CLOCK:
      begin
        if (burst_over)
        begin
          nxt_state = IDLE;
          nxt_since_end = '0;
          nxt_valid = able_ff;
          nxt_word = shift_ff;
          if (able_ff)
          begin
            // acknowledge bit ignored, reserved bits compared as received
            if (have_last_ff && ((shift_ff & flp_pkg::ACK_MASK) == (last_ff & flp_pkg::ACK_MASK)))
            begin
              nxt_match = (match_ff == 2'd3) ? match_ff : match_ff + 2'd1;
            end
            else
            begin
              nxt_match = 2'd1;
            end
            nxt_last = shift_ff;
            nxt_have_last = 1'b1;
            if (nxt_match >= 2'(flp_pkg::MATCH_BURSTS))
            begin
              nxt_ack = 1'b1;
            end
          end
        end
        else if (pulse)
        begin
          // spacing from the previous pulse of any kind, so a fast train never counts
          if (at_least(pulse_gap, FLP_MIN_C))
          begin
            nxt_good = (good_ff == 5'h1f) ? good_ff : good_ff + 5'd1;
          end
          else
          begin
            nxt_good = 5'd1;
          end
          if (nxt_good >= 5'(flp_pkg::ABLE_PULSES))
          begin
            nxt_able = 1'b1;
          end
          if (state_ff == WAIT_DATA && data_one)
          begin
            nxt_state = WAIT_CLOCK;
            if (bits_ff < 6'(flp_pkg::WORD_BITS))
            begin
              nxt_shift[bits_ff[3:0]] = 1'b1;
              nxt_bits = bits_ff + 6'd1;
            end
          end
          else
          begin
            // clock pulse: a missed data slot records zero
            nxt_state = WAIT_DATA;
            if (state_ff == WAIT_DATA && bits_ff < 6'(flp_pkg::WORD_BITS))
            begin
              nxt_shift[bits_ff[3:0]] = 1'b0;
              nxt_bits = bits_ff + 6'd1;
            end
          end
        end
      end
      default:
      begin
        nxt_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      state_ff <= IDLE;
      shift_ff <= '0;
      bits_ff <= '0;
      good_ff <= '0;
      able_ff <= 1'b0;
      match_ff <= '0;
      last_ff <= '0;
      have_last_ff <= 1'b0;
      ack_ff <= 1'b0;
      valid_ff <= 1'b0;
      word_ff <= '0;
      since_end_ff <= '1;
    end
    else
    begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      bits_ff <= nxt_bits;
      good_ff <= nxt_good;
      able_ff <= nxt_able;
      match_ff <= nxt_match;
      last_ff <= nxt_last;
      have_last_ff <= nxt_have_last;
      ack_ff <= nxt_ack;
      valid_ff <= nxt_valid;
      word_ff <= nxt_word;
      since_end_ff <= nxt_since_end;
    end
  end

  assign ABILITY_DETECTED = able_ff;
  assign ACK_DETECT = ack_ff;
  assign WORD_VALID = valid_ff;
  assign RX_WORD = word_ff;

  // reserved bits reach the word as received; only the far end must send them zero
  chk_ack_needs_match: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    $rose(ack_ff) |-> $past(match_ff) >= 2'd2) else $error("ack without matches");
  chk_ack_sticky: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    ack_ff |=> ack_ff) else $error("ack dropped");
  chk_word_needs_able: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    WORD_VALID |-> able_ff) else $error("word before ability");
  chk_able_count: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    $rose(able_ff) |-> good_ff >= 5'd6 && good_ff <= 5'd17) else
    $error("ability count out of range");
  chk_close_pulse: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    pulse && state_ff != IDLE && !burst_over && pulse_gap < TW'(FLP_MIN_C)
    |=> good_ff == 5'd1) else $error("close pulse counted");
  chk_bits_bounded: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    bits_ff <= 6'd16) else $error("bit count beyond word");
  chk_late_zero: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    pulse && state_ff == WAIT_DATA && late && !burst_over && bits_ff < 6'd16
    |=> state_ff == WAIT_DATA && !shift_ff[$past(bits_ff[3:0])]) else
    $error("late pulse not zero");
  chk_one_in_window: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    pulse && state_ff == WAIT_DATA && !burst_over && bits_ff < 6'd16
    && clk_gap >= TW'(DATA_MIN_C) && clk_gap < TW'(DATA_MAX_C)
    |=> state_ff == WAIT_CLOCK) else $error("data one missed");
  chk_burst_ends: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    state_ff != IDLE && clk_gap >= TW'(FLP_MAX_C) |=> state_ff == IDLE) else
    $error("burst end missed");
endmodule

//--- tb/flp_link_partner.sv
`timescale 1ns/1ns
// far-end transmitter: clock pulse every 125 us, a data one 62 us after its clock
module flp_link_partner #(
  parameter int CYC_US = 25 // clock cycles per microsecond of link time
) (
  input wire logic clk,
  output logic pulse_out
);
  initial pulse_out = 1'b0;
  // pulse starts cyc edges after the previous start; two cycles wide for the sync flops
  task automatic gap_pulse(input int cyc);
    repeat (cyc - 2) @(posedge clk);
    pulse_out <= 1'b1;
    repeat (2) @(posedge clk);
    pulse_out <= 1'b0;
  endtask
  // positions lsb first, final clock included; late_pos sends its one past the window
  task automatic send_burst(input logic [31:0] bits, input int n, input int late_pos);
    gap_pulse(2);
    for (int i = 0; i < n; i++)
    begin
      if (bits[i] && i == late_pos)
      begin
        gap_pulse(95 * CYC_US);
        gap_pulse(62 * CYC_US);
      end
      else if (bits[i])
      begin
        gap_pulse(62 * CYC_US);
        gap_pulse(63 * CYC_US);
      end
      else
        gap_pulse(125 * CYC_US);
    end
  endtask
  // plain pulse train, fixed spacing in cycles
  task automatic send_train(input int n, input int cyc);
    gap_pulse(2);
    for (int i = 1; i < n; i++)
      gap_pulse(cyc);
  endtask
endmodule

//--- tb/flp_burst_receive_checker_tb_top.sv
`timescale 1ns/1ns
// bursts go through the far-end model; words, ability and acknowledge detect are checked
module flp_burst_receive_checker_tb_top;
  // one cycle stands for one microsecond of link time, keeping the run near 50k cycles
  localparam int CYC_US = 1;
  localparam int LIMIT = 80000;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic link_pulse;
  logic ability;
  logic ack;
  logic word_valid;
  logic [15:0] rx_word;
  logic [15:0] exp_q[$];
  logic [15:0] w;
  logic watch = 1'b1;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  always #20 core_clk = ~core_clk;
  flp_burst_receive_checker #(.CYC_PER_US(CYC_US)) dut_u (
    .CORE_CLK(core_clk),
    .RSTN(rstn),
    .LINK_PULSE(link_pulse),
    .ABILITY_DETECTED(ability),
    .ACK_DETECT(ack),
    .WORD_VALID(word_valid),
    .RX_WORD(rx_word)
  );

  flp_link_partner #(.CYC_US(CYC_US)) partner_u (
    .clk(core_clk),
    .pulse_out(link_pulse)
  );

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // leftover expected words mean a burst was never reported
  task automatic do_reset();
    chk("pending words", 16'h0, 16'(exp_q.size()));
    exp_q.delete();
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("flags after reset", 16'h0, {14'h0, ability, ack});
  endtask

  task automatic wait_us(input int us);
    repeat (us * CYC_US) @(posedge core_clk);
  endtask

  // one burst, then idle until sp_us after its start; a late 1,0 is noted as 0,1
  task automatic burst(input logic [31:0] bits, input int n, input int late, input int sp_us);
    logic [15:0] e;
    int c0;
    e = bits[15:0];
    c0 = cycles;
    if (late >= 0)
    begin
      e[late] = 1'b0;
      e[late + 1] = 1'b1;
    end
    if (watch)
      exp_q.push_back(e);
    partner_u.send_burst(bits, n, late);
    while (cycles - c0 < sp_us * CYC_US)
      @(posedge core_clk);
  endtask

  // each word pulse retires the oldest noted word
  always @(posedge core_clk)
    if (watch && word_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("unexpected word", 16'h0, rx_word);
      else
        chk("rx word", exp_q.pop_front(), rx_word);
    end

  // hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      bad_count++;
      summarize();
    end
  end

  initial
  begin
    void'($urandom(32'hbbae8e18));
    do_reset();
    partner_u.send_train(20, 5 * CYC_US);
    wait_us(1000);
    chk("ability fast", 16'h0, {15'h0, ability});
    do_reset();
    partner_u.send_train(5, 62 * CYC_US);
    wait_us(1000);
    chk("ability five", 16'h0, {15'h0, ability});
    do_reset();
    exp_q.push_back(16'h000f);
    partner_u.send_train(9, 62 * CYC_US);
    wait_us(1000);
    chk("ability nine", 16'h1, {15'h0, ability});
    // reserved bits set, ack bit differing, long bursts
    do_reset();
    w = (16'($urandom()) & 16'hbfff) | 16'h1c00;
    burst({16'h0, w}, 16, -1, 7000);
    burst({16'h1, w | 16'h4000}, 17, -1, 7000);
    chk("ack after two", 16'h0, {15'h0, ack});
    burst({16'h11, w}, 21, -1, 7000);
    chk("ack after three", 16'h1, {15'h0, ack});
    // bursts too close together never match
    do_reset();
    watch = 1'b0;
    repeat (4) burst({16'h0, w}, 16, -1, 5000);
    chk("ack close bursts", 16'h0, {15'h0, ack});
    watch = 1'b1;
    // late one at position 14, reserved bits sent as zero
    do_reset();
    w = (16'($urandom()) & 16'h03ff) | 16'h4000;
    burst({16'h0, w}, 16, 14, 3000);
    do_reset();
    summarize();
  end
endmodule
